// File: hw/dslk_err_counter.v
/*
  Saturating symbol error counter with threshold compare.
  Assumes symbol strobes synchronous to clk; threshold stable or changed by software.
*/
`timescale 1ns/1ps
`include "dslk_map.vh"

module dslk_err_counter (
  input  wire                    clk,
  input  wire                    nrst,
  input  wire                    clear,
  input  wire                    errSym,
  input  wire [`DSLK_ECNT_W-1:0] threshold,
  output wire                    reached
);

  reg [`DSLK_ECNT_W-1:0] count_q;
  reg [`DSLK_ECNT_W-1:0] count_d;

  // ==================================================================
  // Count errors, saturate so the compare never wraps
  always @* begin
    count_d = count_q;
    if (clear) begin
      count_d = {`DSLK_ECNT_W{1'b0}};
    end else if (errSym && count_q != {`DSLK_ECNT_W{1'b1}}) begin
      count_d = count_q + 5'h01;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= {`DSLK_ECNT_W{1'b0}};
    end else begin
      count_q <= count_d;
    end
  end

  // Zero threshold never fires, avoids a trip with no errors seen
  assign reached = (threshold != {`DSLK_ECNT_W{1'b0}}) && (count_q >= threshold);

endmodule

// File: hw/dslk_lock_ctrl.v
/*
  Receive coding-sublayer lock and link control with Avalon-MM registers.
  Holds the lock state machine, both error threshold counters and the register slave.
  Assumes symbol strobes from the descrambler, one per symbol, synchronous to clk.
  Assumes an Avalon-MM master that holds each request until it sees waitrequest low.
*/
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`include "dslk_map.vh"

module dslk_lock_ctrl (
  input  wire                    clk,
  input  wire                    nrst,
  input  wire [`DSLK_ADDR_W-1:0] avsAddress,
  input  wire                    avsRead,
  input  wire                    avsWrite,
  input  wire [31:0]             avsWriteData,
  input  wire [3:0]              avsByteEnable,
  output reg  [31:0]             avsReadData,
  output reg                     avsWaitRequest,
  output reg  [1:0]              avsResponse,
  input  wire                    symValid,
  input  wire                    symIdle,
  input  wire                    inIpg,
  output reg                     trainEnable,
  output reg                     linkUp,
  output reg                     remRxOk
);

  localparam [2:0] ST_OFF    = 3'h1;
  localparam [2:0] ST_SEARCH = 3'h2;
  localparam [2:0] ST_LOCKED = 3'h4;

  reg  [15:0]             linkCtrl_q;
  reg  [15:0]             errThresh_q;
  reg  [2:0]              state_q;
  reg  [2:0]              state_d;
  reg  [`DSLK_CNT_W-1:0]  idleCnt_q;
  reg  [`DSLK_CNT_W-1:0]  idleCnt_d;
  reg                     ackDone_q;
  wire                    linkEn;
  wire                    ipgDis;
  wire [`DSLK_CNT_W-1:0]  idleTarget;
  wire                    checkSym;
  wire                    errSym;
  wire                    lossHit;
  wire                    rrxHit;
  wire                    errClear;
  wire [15:0]             byteMask;
  wire [15:0]             ctrlMask;

  // ==================================================================
  // Field extraction
  function [15:0] lane_mask;
    input [3:0] be;
    begin
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
    end
  endfunction

  // Byte-lane merge shared by both writable registers
  function [15:0] merge_lanes;
    input [15:0] oldVal;
    input [15:0] newVal;
    input [15:0] mask;
    begin
      merge_lanes = (oldVal & ~mask) | (newVal & mask);
    end
  endfunction

  assign linkEn     = linkCtrl_q[`DSLK_LINK_EN_BIT];
  assign ipgDis     = linkCtrl_q[`DSLK_IPG_DIS_BIT];
  assign idleTarget = linkCtrl_q[`DSLK_IDLE_MSB:0];
  assign byteMask   = lane_mask(avsByteEnable);
  // Read-only bits 11:9 never take write data
  assign ctrlMask   = byteMask & `DSLK_LINK_CTRL_WMASK;

  // Gap symbols are ignored for lock checking only when disabled
  assign checkSym = symValid && !(inIpg && ipgDis);
  assign errSym   = checkSym && !symIdle && state_q == ST_LOCKED;
  // Restart error counting whenever lock is not held
  assign errClear = state_q != ST_LOCKED;

  // ==================================================================
  // Error threshold counters
  dslk_err_counter uLoss (
    .clk       (clk),
    .nrst      (nrst),
    .clear     (errClear),
    .errSym    (errSym),
    .threshold (errThresh_q[`DSLK_LOSS_MSB:`DSLK_LOSS_LSB]),
    .reached   (lossHit)
  );

  dslk_err_counter uRemRx (
    .clk       (clk),
    .nrst      (nrst),
    .clear     (errClear),
    .errSym    (errSym),
    .threshold (errThresh_q[`DSLK_RRX_MSB:0]),
    .reached   (rrxHit)
  );

  // ==================================================================
  // Lock state machine
  always @* begin
    state_d   = state_q;
    idleCnt_d = idleCnt_q;
    case (state_q)
      ST_OFF: begin
        idleCnt_d = {`DSLK_CNT_W{1'b0}};
        if (linkEn) begin
          state_d = ST_SEARCH;
        end
      end
      ST_SEARCH: begin
        if (!linkEn) begin
          state_d   = ST_OFF;
        end else if (idleCnt_q >= idleTarget) begin
          state_d   = ST_LOCKED;
        end else if (checkSym && symIdle) begin
          idleCnt_d = idleCnt_q + 9'h001;
        end else if (checkSym) begin
          // Idles must be consecutive to count as initial idles
          idleCnt_d = {`DSLK_CNT_W{1'b0}};
        end
      end
      ST_LOCKED: begin
        if (!linkEn) begin
          state_d = ST_OFF;
        end else if (lossHit) begin
          state_d   = ST_SEARCH;
          idleCnt_d = {`DSLK_CNT_W{1'b0}};
        end
      end
      default: begin
        state_d   = ST_OFF;
        idleCnt_d = {`DSLK_CNT_W{1'b0}};
      end
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q   <= ST_OFF;
      idleCnt_q <= {`DSLK_CNT_W{1'b0}};
    end else begin
      state_q   <= state_d;
      idleCnt_q <= idleCnt_d;
    end
  end

  // ==================================================================
  // Registered link outputs, decoded from state_d so they change in the same cycle as state_q
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trainEnable <= 1'b0;
      linkUp      <= 1'b0;
      remRxOk     <= 1'b0;
    end else begin
      trainEnable <= linkEn && state_d != ST_OFF;
      linkUp      <= state_d == ST_LOCKED;
      remRxOk     <= state_d == ST_LOCKED && !rrxHit;
    end
  end

  // ==================================================================
  // Avalon-MM slave: one wait cycle, answer on the second edge.
  // Read data is captured when the request is first seen; a write lands only at
  // the edge where the master samples waitrequest low, so no register changes
  // before the transfer has completed on the bus.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      linkCtrl_q     <= `DSLK_LINK_CTRL_RST;
      errThresh_q    <= `DSLK_ERR_THRESH_RST;
      avsReadData    <= 32'h00000000;
      avsWaitRequest <= 1'b1;
      avsResponse    <= 2'h0;
      ackDone_q      <= 1'b0;
    end else begin
      avsWaitRequest <= 1'b1;
      ackDone_q      <= 1'b0;
      if ((avsRead || avsWrite) && avsWaitRequest && !ackDone_q) begin
        avsWaitRequest <= 1'b0;
        ackDone_q      <= 1'b1;
        avsResponse    <= 2'h0;
        avsReadData    <= 32'h00000000;
        case (avsAddress)
          `DSLK_ADDR_LINK_CTRL: begin
            avsReadData <= {16'h0000, linkCtrl_q};
          end
          `DSLK_ADDR_ERR_THRESH: begin
            avsReadData <= {16'h0000, errThresh_q};
          end
          `DSLK_ADDR_STATUS: begin
            avsReadData <= {29'h00000000, trainEnable, remRxOk, linkUp};
          end
          default: begin
            // Unmapped: answer with slave error, reads return zero
            avsResponse <= 2'h2;
          end
        endcase
      end
      // Commit: ackDone_q marks the one cycle in which waitrequest is low
      if (avsWrite && ackDone_q) begin
        case (avsAddress)
          `DSLK_ADDR_LINK_CTRL: begin
            linkCtrl_q <= merge_lanes(linkCtrl_q, avsWriteData[15:0], ctrlMask);
          end
          `DSLK_ADDR_ERR_THRESH: begin
            errThresh_q <= merge_lanes(errThresh_q, avsWriteData[15:0], byteMask);
          end
          default: begin
            // Status is read-only and unmapped writes are dropped
          end
        endcase
      end
    end
  end

endmodule

// File: inc/dslk_map.vh
/*
  Register map, field positions and reset values of the descrambler lock
  and link control block.
  Assumes a 32-bit Avalon-MM slave with word addressing by byte address.
*/
`ifndef DSLK_MAP_VH
`define DSLK_MAP_VH

// ==================================================================
// Register indices and byte addresses
`define DSLK_IDX_LINK_CTRL    16'h0485
`define DSLK_IDX_ERR_THRESH   16'h0486
`define DSLK_IDX_STATUS       16'h0490
`define DSLK_ADDR_W           18
`define DSLK_ADDR_LINK_CTRL   18'h01214
`define DSLK_ADDR_ERR_THRESH  18'h01218
`define DSLK_ADDR_STATUS      18'h01240

// ==================================================================
// Link control fields
`define DSLK_IPG_DIS_BIT      13
`define DSLK_LINK_EN_BIT      12
`define DSLK_IDLE_MSB         8
`define DSLK_LINK_CTRL_RST    16'h1078
`define DSLK_LINK_CTRL_WMASK  16'hF1FF

// ==================================================================
// Error threshold fields
`define DSLK_LOSS_MSB         13
`define DSLK_LOSS_LSB         9
`define DSLK_RRX_MSB          4
`define DSLK_ERR_THRESH_RST   16'h0A05

// ==================================================================
// Status bits and counter widths
`define DSLK_ST_LOCK_BIT      0
`define DSLK_ST_RRX_BIT       1
`define DSLK_ST_TRAIN_BIT     2
`define DSLK_CNT_W            9
`define DSLK_ECNT_W           5

`endif

// File: sim/dslk_lock_ctrl_bench.sv
/* Self-checking bench for the lock block.
   Assumes the remote PHY model and the bound checker. */
`timescale 1ns/1ps
`include "dslk_map.vh"
// ========
// Bench
module dslk_lock_ctrl_bench;
  logic                    clk;
  logic                    nrst = 1'b0;
  logic [`DSLK_ADDR_W-1:0] avsAddress = '0;
  logic                    avsRead = 1'b0;
  logic                    avsWrite = 1'b0;
  logic [31:0]             avsWriteData = '0;
  logic [3:0]              avsByteEnable = 4'h3;
  wire  [31:0]             avsReadData;
  wire  [1:0]              avsResponse;
  wire                     avsWaitRequest, symValid, symIdle, inIpg;
  wire                     trainEnable, linkUp, remRxOk;
  logic [17:0]             expQ [$];
  logic [8:0]              idleN;
  logic [15:0]             ctl;
  int                      fail_count = 0, compares = 0, cycles = 0, testNo = 0;
  int                      seed = 28252;
  dslk_lock_ctrl dslk_lock_ctrl_i (.clk(clk), .nrst(nrst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .avsResponse(avsResponse), .symValid(symValid), .symIdle(symIdle), .inIpg(inIpg),
    .trainEnable(trainEnable), .linkUp(linkUp), .remRxOk(remRxOk));
  dslk_phy_model dslk_phy_model_i (.clk(clk), .symValid(symValid), .symIdle(symIdle),
    .inIpg(inIpg));
  task chk(input logic [17:0] seen, input logic [17:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until waitrequest is sampled low at a rising edge
  task bus(input logic w, input logic [17:0] a, input logic [15:0] d);
    @(posedge clk);
    avsRead <= !w;
    avsWrite <= w;
    avsAddress <= a;
    avsWriteData <= {16'h0000, d};
    @(posedge clk);
    while (avsWaitRequest !== 1'b0) @(posedge clk);
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task rd(input logic [17:0] a, input logic [17:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask
  task fin;
    testNo++;
    $display("test %0d done", testNo);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Monitor: response and data of each accepted read against the oldest note
  always @(posedge clk) begin
    if (avsRead && avsWaitRequest === 1'b0 && expQ.size() > 0)
      chk({avsResponse, avsReadData[15:0]}, expQ.pop_front());
  end
  // Hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    idleN = 9'h002 + {6'h00, 3'($random(seed))};
    ctl = {7'h08, idleN};
    rd(`DSLK_ADDR_LINK_CTRL, 18'h01078);
    rd(`DSLK_ADDR_ERR_THRESH, 18'h00A05);
    rd(`DSLK_ADDR_STATUS, 18'h00004);
    rd(18'h01300, 18'h20000);
    fin();
    // Reserved bits written high must read back zero
    bus(1'b1, `DSLK_ADDR_LINK_CTRL, ctl | 16'h0E00);
    bus(1'b1, `DSLK_ADDR_ERR_THRESH, 16'h0C03);
    rd(`DSLK_ADDR_LINK_CTRL, {2'h0, ctl});
    dslk_phy_model_i.send(idleN - 1, 1'b1, 1'b0);
    rd(`DSLK_ADDR_STATUS, 18'h00004);
    dslk_phy_model_i.send(1, 1'b1, 1'b0);
    rd(`DSLK_ADDR_STATUS, 18'h00007);
    fin();
    dslk_phy_model_i.send(3, 1'b0, 1'b0);
    rd(`DSLK_ADDR_STATUS, 18'h00005);
    dslk_phy_model_i.send(3, 1'b0, 1'b0);
    rd(`DSLK_ADDR_STATUS, 18'h00004);
    dslk_phy_model_i.send(idleN - 1, 1'b1, 1'b0);
    rd(`DSLK_ADDR_STATUS, 18'h00004);
    dslk_phy_model_i.send(1, 1'b1, 1'b0);
    rd(`DSLK_ADDR_STATUS, 18'h00007);
    fin();
    bus(1'b1, `DSLK_ADDR_LINK_CTRL, ctl | 16'h2000);
    dslk_phy_model_i.send(6, 1'b0, 1'b1);
    rd(`DSLK_ADDR_STATUS, 18'h00007);
    bus(1'b1, `DSLK_ADDR_LINK_CTRL, ctl);
    dslk_phy_model_i.send(6, 1'b0, 1'b1);
    rd(`DSLK_ADDR_STATUS, 18'h00004);
    fin();
    bus(1'b1, `DSLK_ADDR_LINK_CTRL, {7'h00, idleN});
    rd(`DSLK_ADDR_STATUS, 18'h00000);
    // Low lane only: idle bits 7:0 take the data, the high byte with idle bit 8 and the enables keeps its zeros
    avsByteEnable <= 4'h1;
    bus(1'b1, `DSLK_ADDR_LINK_CTRL, 16'hFFFF);
    rd(`DSLK_ADDR_LINK_CTRL, 18'h000FF);
    fin();
    repeat (2) @(posedge clk);
    conclude();
  end
endmodule

// File: sim/dslk_lock_ctrl_sva.sv
/* Port assertions for the lock block.
   Assumes software writes link control through byte lane 1. */
`timescale 1ns/1ps
`include "dslk_map.vh"
// ========
// Checker
module dslk_lock_ctrl_sva (
  input wire                    clk,
  input wire                    nrst,
  input wire [`DSLK_ADDR_W-1:0] avsAddress,
  input wire                    avsWrite,
  input wire [31:0]             avsWriteData,
  input wire [3:0]              avsByteEnable,
  input wire                    avsWaitRequest,
  input wire                    symValid,
  input wire                    symIdle,
  input wire                    trainEnable,
  input wire                    linkUp,
  input wire                    remRxOk
);
  reg       linkEn_q;
  reg [2:0] idleH_q;
  reg [2:0] errH_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Enable shadow and short symbol history, so edges can be tied to causes
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      linkEn_q <= 1'b1;
      idleH_q <= 3'h0;
      errH_q <= 3'h0;
    end else begin
      idleH_q <= {idleH_q[1:0], symValid & symIdle};
      errH_q <= {errH_q[1:0], symValid & ~symIdle};
      if (avsWrite && !avsWaitRequest && avsByteEnable[1] &&
          avsAddress == `DSLK_ADDR_LINK_CTRL) linkEn_q <= avsWriteData[12];
    end
  end
  sequence offHeld;
    !linkEn_q [*3];
  endsequence
  link_off_a: assert property (offHeld |-> !trainEnable && !linkUp && !remRxOk)
    else $error("outputs active while link control off");
  train_on_a: assert property (linkEn_q [*4] |-> trainEnable)
    else $error("training held off while enabled");
  lock_rise_a: assert property ($rose(linkUp) |-> |idleH_q[2:1])
    else $error("link rose without a recent idle");
  lock_loss_a: assert property ($fell(linkUp) |-> (|errH_q) || !linkEn_q)
    else $error("link fell without an error symbol");
  rrx_drop_a: assert property ($fell(remRxOk) |-> (|errH_q) || !linkEn_q)
    else $error("remote status fell without an error symbol");
  wait_pulse_a: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low for more than a cycle");
endmodule
bind dslk_lock_ctrl dslk_lock_ctrl_sva dslk_lock_ctrl_sva_i (.clk(clk), .nrst(nrst),
  .avsAddress(avsAddress), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
  .avsByteEnable(avsByteEnable), .avsWaitRequest(avsWaitRequest), .symValid(symValid),
  .symIdle(symIdle), .trainEnable(trainEnable), .linkUp(linkUp), .remRxOk(remRxOk));

// File: sim/dslk_phy_model.sv
/* Remote PHY symbol source for the lock block.
   Assumes the bench calls send from its main process. */
`timescale 1ns/1ps
// ========
// Symbol source
module dslk_phy_model (
  input  wire  clk,
  output logic symValid,
  output logic symIdle,
  output logic inIpg
);
  initial {symValid, symIdle, inIpg} = 3'h0;
  // One symbol every other cycle; idle flag garbled between symbols
  task send(input int n, input logic idle, input logic ipg);
    repeat (n) begin
      @(posedge clk);
      {symValid, symIdle, inIpg} <= {1'b1, idle, ipg};
      @(posedge clk);
      {symValid, symIdle} <= {1'b0, ~idle};
    end
    repeat (3) @(posedge clk);
  endtask
endmodule
